// *** design/rxf_consts.vh ***
// Constants of the receive FIFO status and control block.
`ifndef RXF_CONSTS_VH
`define RXF_CONSTS_VH
`define RXF_ADDR_STATUS 16'h84C4
`define RXF_ADDR_CONTROL 16'h84C8
`define RXF_ADDR_WATERMARK 16'h84CC
`define RXF_ADDR_READ_PTR 16'h84D0
`define RXF_ADDR_WRITE_PTR 16'h84D4
`define RXF_BIT_BAD_POINTER 31
`define RXF_BIT_SEND_WAIT 30
`define RXF_BIT_FRAME_ACC_ERR 23
`define RXF_BIT_RECV_WAIT 22
`define RXF_BIT_UNDERFLOW 21
`define RXF_BIT_OVERFLOW 20
`define RXF_BIT_FRAME_READY 19
`define RXF_BIT_FULL 18
`define RXF_BIT_ALARM 17
`define RXF_BIT_EMPTY 16
`define RXF_BIT_WRITE_FRAME 29
`define RXF_GRAN_HI 26
`define RXF_GRAN_LO 24
`define RXF_BIT_BAD_POINTER_MASK 23
`define RXF_BIT_FRAME_ACC_MASK 22
`define RXF_BIT_RECV_WAIT_MASK 21
`define RXF_BIT_UNDERFLOW_MASK 20
`define RXF_BIT_OVERFLOW_MASK 19
`define RXF_BIT_SEND_WAIT_MASK 18
`define RXF_MASK_RESET 6'h09
`define RXF_PTR_HI 6
`define RXF_FIFO_BYTES 8'h80
`define RXF_WORD_BYTES 8'h04
`define RXF_MAX_BEATS 8
`endif

// *** design/rxf_status_ctrl.v ***
// Status, control, watermark and pointer logic of the receive FIFO.
`timescale 1ns/1ps
`include "rxf_consts.vh"
// Notes on behaviour
// (R1) Sticky flags: hardware sets, software writes one clears.
// (R2) Out-of-range pointer write sets bad pointer flag.
// (R3) Send wait flag never asserts here.
// (R4) Refused push sets receive wait flag.
// (R5) Pop beyond empty sets underflow flag.
// (R6) Push beyond full sets overflow flag.
// (R7) Software ignores frame error and frame ready.
// (R8) Full bit tracks present occupancy.
// (R9) Alarm bit shows watermark state, unlatched.
// (R10) Empty bit live, one after reset.
// (R11) Software keeps write frame bit zero.
// (R12) Granularity gives bytes-remaining alarm release level.
// (R13) Granularity above 128 minus alarm avoided.
// (R14) Six masks gate flags onto error output.
// (R15) Receive and send wait masks reset to one.
// (R16) Alarm raised when free bytes at or below watermark.
// (R17) Alarm held until bytes remaining reach granularity.
// (R18) Burst room needs four bytes times beats.
// (R19) Software sets alarm at least burst size.
// (R20) Read pointer is RAM read address.
// (R21) Write pointer is RAM write address.
// (R22) Controller error flag set by unmasked errors.
// (R23) Data port used with full words only.
// (R24) Error output is OR of unmasked flags.
module rxf_status_ctrl #(
  parameter MAX_BEATS = `RXF_MAX_BEATS
) (
  input wire clk,
  input wire rst_n,
  input wire fifo_reset,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire rx_push,
  input wire dma_pop,
  input wire fe_clear,
  output reg rx_room,
  output reg dma_req,
  output reg fifo_error,
  output reg fifo_error_flag,
  output reg [6:0] ram_read_index,
  output reg [6:0] ram_write_index
);

  // ************************************************************
  // Bus address phase capture
  // ************************************************************
  localparam integer BURST_INT = MAX_BEATS * 4;
  localparam [7:0] BURST_BYTES = BURST_INT[7:0];
  reg wr_pend;
  reg [15:0] wr_addr;
  wire addr_ok;
  assign addr_ok = hsel & hready & htrans[1];

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_addr <= 16'h0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      // Zero wait states: every transfer completes in its data phase.
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= addr_ok & hwrite;
      if (addr_ok) begin
        wr_addr <= haddr[15:0];
      end
    end
  end

  wire wr_status;
  wire wr_control;
  wire wr_mark;
  wire wr_rptr;
  wire wr_wptr;
  assign wr_status = wr_pend & (wr_addr == `RXF_ADDR_STATUS);
  assign wr_control = wr_pend & (wr_addr == `RXF_ADDR_CONTROL);
  assign wr_mark = wr_pend & (wr_addr == `RXF_ADDR_WATERMARK);
  assign wr_rptr = wr_pend & (wr_addr == `RXF_ADDR_READ_PTR);
  assign wr_wptr = wr_pend & (wr_addr == `RXF_ADDR_WRITE_PTR);

  // ************************************************************
  // Control and watermark registers
  // ************************************************************
  reg write_frame_ctl;
  reg [2:0] granularity_level;
  reg bad_pointer_mask;
  reg frame_accept_err_mask;
  reg recv_wait_mask;
  reg underflow_mask;
  reg overflow_mask;
  reg send_wait_mask;
  reg [6:0] alarm_level;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      write_frame_ctl <= 1'b0;
      granularity_level <= 3'h0;
      // (R15) wait masks set
      {bad_pointer_mask, frame_accept_err_mask, recv_wait_mask,
       underflow_mask, overflow_mask, send_wait_mask} <= `RXF_MASK_RESET;
      alarm_level <= 7'h00;
    end else begin
      if (wr_control) begin
        write_frame_ctl <= hwdata[`RXF_BIT_WRITE_FRAME];
        granularity_level <= hwdata[`RXF_GRAN_HI:`RXF_GRAN_LO];
        bad_pointer_mask <= hwdata[`RXF_BIT_BAD_POINTER_MASK];
        frame_accept_err_mask <= hwdata[`RXF_BIT_FRAME_ACC_MASK];
        recv_wait_mask <= hwdata[`RXF_BIT_RECV_WAIT_MASK];
        underflow_mask <= hwdata[`RXF_BIT_UNDERFLOW_MASK];
        overflow_mask <= hwdata[`RXF_BIT_OVERFLOW_MASK];
        send_wait_mask <= hwdata[`RXF_BIT_SEND_WAIT_MASK];
      end
      if (wr_mark) begin
        alarm_level <= hwdata[`RXF_PTR_HI:0];
      end
    end
  end

  // ************************************************************
  // Pointers and occupancy
  // ************************************************************
  reg [7:0] fill;
  reg [7:0] next_fill;
  reg [6:0] next_rptr;
  reg [6:0] next_wptr;
  reg push_ok;
  reg pop_ok;
  wire [7:0] free_bytes;
  assign free_bytes = `RXF_FIFO_BYTES - fill;

  always @* begin
    // A word needs four free bytes; otherwise the push is refused.
    push_ok = rx_push & (free_bytes >= `RXF_WORD_BYTES);
    pop_ok = dma_pop & (fill >= `RXF_WORD_BYTES);
    next_rptr = ram_read_index;
    next_wptr = ram_write_index;
    next_fill = fill;
    if (wr_rptr | wr_wptr) begin
      // (R20) software read pointer
      if (wr_rptr) begin
        next_rptr = hwdata[`RXF_PTR_HI:0];
      end
      // (R21) software write pointer
      if (wr_wptr) begin
        next_wptr = hwdata[`RXF_PTR_HI:0];
      end
      // Overwritten pointers lose the wrap state; equal means empty.
      next_fill = {1'b0, next_wptr - next_rptr};
    end else begin
      // (R21) write address advance
      if (push_ok) begin
        next_wptr = ram_write_index + 7'h04;
      end
      // (R20) read address advance
      if (pop_ok) begin
        next_rptr = ram_read_index + 7'h04;
      end
      if (push_ok & ~pop_ok) begin
        next_fill = fill + `RXF_WORD_BYTES;
      end else if (pop_ok & ~push_ok) begin
        next_fill = fill - `RXF_WORD_BYTES;
      end
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_read_index <= 7'h00;
      ram_write_index <= 7'h00;
      fill <= 8'h00;
    end else if (fifo_reset) begin
      ram_read_index <= 7'h00;
      ram_write_index <= 7'h00;
      fill <= 8'h00;
    end else begin
      ram_read_index <= next_rptr;
      ram_write_index <= next_wptr;
      fill <= next_fill;
    end
  end

  // ************************************************************
  // Live indications and alarm hysteresis
  // ************************************************************
  reg full_bit;
  reg empty_bit;
  reg alarm_bit;
  wire [7:0] next_free;
  reg next_alarm;
  assign next_free = `RXF_FIFO_BYTES - next_fill;

  always @* begin
    next_alarm = alarm_bit;
    // (R17) hold until low fill
    if (next_fill <= {5'h00, granularity_level}) begin
      next_alarm = 1'b0;
    // (R16) free at or below watermark
    end else if (next_free <= {1'b0, alarm_level}) begin
      next_alarm = 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      full_bit <= 1'b0;
      empty_bit <= 1'b1;
      alarm_bit <= 1'b0;
      dma_req <= 1'b0;
      rx_room <= 1'b0;
    end else if (fifo_reset) begin
      full_bit <= 1'b0;
      empty_bit <= 1'b1;
      alarm_bit <= 1'b0;
      dma_req <= 1'b0;
      rx_room <= 1'b0;
    end else begin
      // (R8) full tracks occupancy
      full_bit <= (next_fill == `RXF_FIFO_BYTES);
      // (R10) empty tracks occupancy
      empty_bit <= (next_fill == 8'h00);
      // (R9) alarm unlatched view
      alarm_bit <= next_alarm;
      // (R12) granularity release request
      dma_req <= next_alarm;
      // (R18) room for burst
      rx_room <= (next_free >= BURST_BYTES);
    end
  end

  // ************************************************************
  // Sticky flags and error output
  // ************************************************************
  reg bad_pointer_flag;
  reg send_wait_flag;
  reg frame_accept_err_flag;
  reg recv_wait_flag;
  reg underflow_flag;
  reg overflow_flag;
  wire frame_ready_flag;
  wire [31:0] clr;
  wire set_bad;
  wire set_rxw;
  wire set_uf;
  wire set_of;
  wire next_err;
  assign clr = wr_status ? hwdata : 32'h00000000;
  // (R2) out-of-range pointer value
  assign set_bad = (wr_rptr | wr_wptr) & (|hwdata[31:7]);
  // (R4) refused incoming word
  assign set_rxw = rx_push & ~push_ok;
  // (R6) written beyond full
  assign set_of = rx_push & (fill == `RXF_FIFO_BYTES);
  // (R5) read beyond empty
  assign set_uf = dma_pop & ~pop_ok;
  // Framing is not supported, so frame ready never rises.
  assign frame_ready_flag = 1'b0;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bad_pointer_flag <= 1'b0;
      send_wait_flag <= 1'b0;
      frame_accept_err_flag <= 1'b0;
      recv_wait_flag <= 1'b0;
      underflow_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else if (fifo_reset) begin
      bad_pointer_flag <= 1'b0;
      send_wait_flag <= 1'b0;
      frame_accept_err_flag <= 1'b0;
      recv_wait_flag <= 1'b0;
      underflow_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      // (R1) set wins over clear
      bad_pointer_flag <= set_bad |
        (bad_pointer_flag & ~clr[`RXF_BIT_BAD_POINTER]);
      // (R3) send wait never set
      send_wait_flag <= send_wait_flag & ~clr[`RXF_BIT_SEND_WAIT];
      frame_accept_err_flag <= frame_accept_err_flag &
        ~clr[`RXF_BIT_FRAME_ACC_ERR];
      recv_wait_flag <= set_rxw |
        (recv_wait_flag & ~clr[`RXF_BIT_RECV_WAIT]);
      underflow_flag <= set_uf |
        (underflow_flag & ~clr[`RXF_BIT_UNDERFLOW]);
      overflow_flag <= set_of |
        (overflow_flag & ~clr[`RXF_BIT_OVERFLOW]);
    end
  end

  // (R14) masks gate flags
  // (R24) OR of unmasked flags
  assign next_err = (bad_pointer_flag & ~bad_pointer_mask) |
    (send_wait_flag & ~send_wait_mask) |
    (frame_accept_err_flag & ~frame_accept_err_mask) |
    (recv_wait_flag & ~recv_wait_mask) |
    (underflow_flag & ~underflow_mask) |
    (overflow_flag & ~overflow_mask);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_error <= 1'b0;
      fifo_error_flag <= 1'b0;
    end else begin
      fifo_error <= next_err;
      // (R22) re-asserts while error stands
      fifo_error_flag <= next_err | (fifo_error_flag & ~fe_clear);
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  reg [31:0] rd_word;

  always @* begin
    rd_word = 32'h00000000;
    case (haddr[15:0])
      `RXF_ADDR_STATUS: begin
        rd_word[`RXF_BIT_BAD_POINTER] = bad_pointer_flag;
        rd_word[`RXF_BIT_SEND_WAIT] = send_wait_flag;
        rd_word[`RXF_BIT_FRAME_ACC_ERR] = frame_accept_err_flag;
        rd_word[`RXF_BIT_RECV_WAIT] = recv_wait_flag;
        rd_word[`RXF_BIT_UNDERFLOW] = underflow_flag;
        rd_word[`RXF_BIT_OVERFLOW] = overflow_flag;
        rd_word[`RXF_BIT_FRAME_READY] = frame_ready_flag;
        rd_word[`RXF_BIT_FULL] = full_bit;
        rd_word[`RXF_BIT_ALARM] = alarm_bit;
        rd_word[`RXF_BIT_EMPTY] = empty_bit;
      end
      `RXF_ADDR_CONTROL: begin
        rd_word[`RXF_BIT_WRITE_FRAME] = write_frame_ctl;
        rd_word[`RXF_GRAN_HI:`RXF_GRAN_LO] = granularity_level;
        rd_word[`RXF_BIT_BAD_POINTER_MASK] = bad_pointer_mask;
        rd_word[`RXF_BIT_FRAME_ACC_MASK] = frame_accept_err_mask;
        rd_word[`RXF_BIT_RECV_WAIT_MASK] = recv_wait_mask;
        rd_word[`RXF_BIT_UNDERFLOW_MASK] = underflow_mask;
        rd_word[`RXF_BIT_OVERFLOW_MASK] = overflow_mask;
        rd_word[`RXF_BIT_SEND_WAIT_MASK] = send_wait_mask;
      end
      `RXF_ADDR_WATERMARK: begin
        rd_word[`RXF_PTR_HI:0] = alarm_level;
      end
      `RXF_ADDR_READ_PTR: begin
        rd_word[`RXF_PTR_HI:0] = ram_read_index;
      end
      `RXF_ADDR_WRITE_PTR: begin
        rd_word[`RXF_PTR_HI:0] = ram_write_index;
      end
      default: begin
        rd_word = 32'h00000000;
      end
    endcase
  end

  // Read data is sampled at the address phase so it stands in the data
  // phase with no wait state; a write in that same edge is not yet seen.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_ok & ~hwrite) begin
      hrdata <= rd_word;
    end
  end

endmodule // rxf_status_ctrl

// *** verification/rxf_partner.sv ***
// Model of the receive controller and DMA engine around the FIFO.
`timescale 1ns/1ps
module rxf_partner (
  input wire [1:0] mode,
  input wire [1:0] rnd,
  input wire rx_room,
  input wire dma_req,
  output wire rx_push,
  output wire dma_pop
);
  // Mode 1 is polite traffic. Modes 2 and 3 push or pop blindly, on purpose.
  // Each pulse carries one whole 32-bit word.
  // push on room
  assign rx_push = (mode == 2'h2) || (mode == 2'h1 && rx_room && rnd[0]);
  assign dma_pop = (mode == 2'h3) || (mode == 2'h1 && dma_req && rnd[1]);
endmodule // rxf_partner

// *** verification/rxf_status_ctrl_checker.sv ***
// Port assertions for the receive FIFO status block.
`timescale 1ns/1ps
module rxf_checker (
  input wire clk,
  input wire rst_n,
  input wire fifo_reset,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire rx_push,
  input wire dma_pop,
  input wire fe_clear,
  input wire rx_room,
  input wire dma_req,
  input wire fifo_error,
  input wire fifo_error_flag,
  input wire [6:0] ram_read_index,
  input wire [6:0] ram_write_index
);
  // ***
  // Helper logic
  // ***
  // A software write may move pointers, so two cycles around it are skipped.
  reg wdp;
  reg wdp2;
  wire sw = wdp | wdp2;
  wire [6:0] fill = ram_write_index - ram_read_index;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdp <= 1'b0;
      wdp2 <= 1'b0;
    end else begin
      wdp <= hsel && htrans[1] && hwrite && hready;
      wdp2 <= wdp;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_push_step: assert property (rx_push && rx_room && !sw && !fifo_reset
    |=> ram_write_index == $past(ram_write_index) + 7'h04)
    else $error("push did not advance write index");
  a_wp_hold: assert property (!rx_push && !sw && !fifo_reset
    |=> $stable(ram_write_index)) else $error("write index moved alone");
  a_rp_hold: assert property (!dma_pop && !sw && !fifo_reset
    |=> $stable(ram_read_index)) else $error("read index moved alone");
  a_room_level: assert property (fill != 7'h00 && !sw
    |-> rx_room == (fill <= 7'h60)) else $error("room flag wrong");
  a_err_flag: assert property (fifo_error |-> fifo_error_flag)
    else $error("error flag missing");
  a_clear_flag: assert property (fe_clear
    |=> fifo_error_flag == fifo_error) else $error("flag clear wrong");
  a_reset_idx: assert property (fifo_reset
    |=> ram_read_index == 7'h00 && ram_write_index == 7'h00 && !dma_req)
    else $error("fifo reset left state");
  a_reset_err: assert property (fifo_reset ##1 fifo_reset
    |=> !fifo_error) else $error("error survived fifo reset");
  a_bus_okay: assert property ($past(rst_n) |-> hreadyout && !hresp)
    else $error("bus slave stalled or erred");
  c_req: cover property ($rose(dma_req));
  c_err: cover property ($rose(fifo_error));
  c_both: cover property (rx_push && dma_pop);
endmodule // rxf_checker
bind rxf_status_ctrl rxf_checker chk_u (.clk(clk), .rst_n(rst_n),
  .fifo_reset(fifo_reset), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .rx_push(rx_push),
  .dma_pop(dma_pop), .fe_clear(fe_clear), .rx_room(rx_room),
  .dma_req(dma_req), .fifo_error(fifo_error),
  .fifo_error_flag(fifo_error_flag), .ram_read_index(ram_read_index),
  .ram_write_index(ram_write_index));

// *** verification/tb_top.sv ***
// Self-checking bench for the receive FIFO status block.
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg fifo_reset = 1'b0;
  reg fe_clear = 1'b0;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [1:0] mode = 2'h0;
  reg [1:0] rnd = 2'h0;
  reg [31:0] q;
  wire [31:0] hrdata;
  wire hreadyout, rx_push, dma_pop, rx_room, dma_req, fe, fef;
  wire [6:0] rp;
  wire [6:0] wp;
  integer error_cnt = 0;
  integer comparisons = 0;
  integer cyc = 0;
  integer np = 0;
  integer nq = 0;
  always #20 clk = ~clk;
  rxf_status_ctrl dut_u (.clk(clk), .rst_n(rst_n), .fifo_reset(fifo_reset),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(), .rx_push(rx_push), .dma_pop(dma_pop),
    .fe_clear(fe_clear), .rx_room(rx_room), .dma_req(dma_req),
    .fifo_error(fe), .fifo_error_flag(fef), .ram_read_index(rp),
    .ram_write_index(wp));
  rxf_partner far_u (.mode(mode), .rnd(rnd), .rx_room(rx_room),
    .dma_req(dma_req), .rx_push(rx_push), .dma_pop(dma_pop));
  // ***
  // Tasks
  // ***
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [15:0] a, input [31:0] d);
    begin
      haddr <= {16'h0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
    end
  endtask
  task rd(input [15:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, e);
    end
  endtask
  task run(input [1:0] m, input integer n);
    begin
      mode <= m;
      repeat (n) @(posedge clk);
      mode <= 2'h0;
      #1;
    end
  endtask
  task print_verdict;
    begin
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Counts polite traffic and bounds the run.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (mode == 2'h1) begin
      np = np + rx_push;
      nq = nq + dma_pop;
    end
    rnd <= 2'($urandom);
    if (cyc == 5000) begin
      error_cnt = error_cnt + 1;
      print_verdict;
    end
  end
  initial begin
    void'($urandom(43));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(16'h84C4, 32'h00010000);
    rd(16'h84C8, 32'h00240000);
    rd(16'h84D4, 32'h0);
    bus(1'b1, 16'h84E0, 32'hFFFFFFFF);
    rd(16'h84E0, 32'h0);
    bus(1'b1, 16'h84CC, 32'h20);
    bus(1'b1, 16'h84C8, 32'h04240000);
    run(2'h2, 23);
    chk({31'h0, dma_req}, 32'h0);
    run(2'h2, 1);
    chk({31'h0, dma_req}, 32'h1);
    run(2'h2, 32);
    rd(16'h84C4, 32'h00560000);
    chk({30'h0, fe, fef}, 32'h3);
    bus(1'b1, 16'h84C4, 32'h0);
    rd(16'h84C4, 32'h00560000);
    bus(1'b1, 16'h84C4, 32'h00100000);
    rd(16'h84C4, 32'h00460000);
    chk({31'h0, fe}, 32'h0);
    bus(1'b1, 16'h84C8, 32'h04000000);
    rd(16'h84C4, 32'h00460000);
    chk({31'h0, fe}, 32'h1);
    bus(1'b1, 16'h84C4, 32'h00400000);
    rd(16'h84C4, 32'h00060000);
    fe_clear <= 1'b1;
    @(posedge clk);
    fe_clear <= 1'b0;
    #1;
    chk({31'h0, fef}, 32'h0);
    run(2'h3, 30);
    chk({31'h0, dma_req}, 32'h1);
    run(2'h3, 1);
    chk({31'h0, dma_req}, 32'h0);
    run(2'h3, 2);
    rd(16'h84C4, 32'h00210000);
    bus(1'b1, 16'h84D4, 32'h10);
    bus(1'b1, 16'h84D0, 32'h84);
    rd(16'h84C4, 32'h80200000);
    rd(16'h84D0, 32'h4);
    chk({25'h0, wp}, 32'h10);
    fifo_reset <= 1'b1;
    repeat (2) @(posedge clk);
    fifo_reset <= 1'b0;
    rd(16'h84C4, 32'h00010000);
    rd(16'h84C8, 32'h04000000);
    #1;
    np = 0;
    nq = 0;
    run(2'h1, 400);
    chk({25'h0, wp}, (4 * np) % 128);
    chk({25'h0, rp}, (4 * nq) % 128);
    print_verdict;
  end
endmodule // tb_top
